// [verilog/i2c_resv_defs.vh]
// constants for the reserved-address decoder of a two-wire bus target
// assumes the includer wants byte classes, reserved codes and fsm states
`ifndef I2C_RESV_DEFS_VH
`define I2C_RESV_DEFS_VH

`define CL_NORMAL 4'h0
`define CL_GCALL 4'h1
`define CL_SBYTE 4'h2
`define CL_FOREIGN 4'h3
`define CL_FORMAT 4'h4
`define CL_FUTURE 4'h5
`define CL_HSCODE 4'h6
`define CL_TENBIT 4'h7
`define CL_DEVID 4'h8

`define ADDR_GCALL 7'h00
`define ADDR_FOREIGN 7'h01
`define ADDR_FORMAT 7'h02
`define ADDR_FUTURE 7'h03
`define PFX_HSCODE 5'h01
`define PFX_TENBIT 5'h1E
`define PFX_DEVID 5'h1F
`define GC_RESET_CMD 8'h06
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8

`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_GCMD 3'h2
`define ST_WR 3'h3
`define ST_RD 3'h4
`define ST_SKIP 3'h5

`endif

// [verilog/bus_pin_sync.v]
// pin synchroniser and bus condition detector for clock and data lines
// assumes both lines arrive asynchronously from open-drain pins
`timescale 1ns/1ps
`default_nettype none
module bus_pin_sync (
	input wire clk,
	input wire rst_n,
	input wire scl_in,
	input wire sda_in,
	output wire scl_s,
	output wire sda_s,
	output wire scl_rise,
	output wire scl_fall,
	output wire start_det,
	output wire stop_det
);
	reg [1:0] scl_meta_r;
	reg [1:0] sda_meta_r;
	reg scl_p_r;
	reg sda_p_r;

	// idle bus is high, so reset to high to avoid a false start
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_meta_r <= 2'h3;
			sda_meta_r <= 2'h3;
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else begin
			scl_meta_r <= {scl_meta_r[0], scl_in};
			sda_meta_r <= {sda_meta_r[0], sda_in};
			scl_p_r <= scl_meta_r[1];
			sda_p_r <= sda_meta_r[1];
		end
	end

	assign scl_s = scl_meta_r[1];
	assign sda_s = sda_meta_r[1];
	assign scl_rise = scl_s & ~scl_p_r;
	assign scl_fall = ~scl_s & scl_p_r;
	// data falls with clock high: controller pulls data before clock
	assign start_det = scl_s & scl_p_r & sda_p_r & ~sda_s;
	assign stop_det = scl_s & scl_p_r & ~sda_p_r & sda_s;
endmodule
`default_nettype wire

// [verilog/first_byte_class.v]
// classifies the first byte after a start into reserved and normal classes
// assumes a full byte, address in bits 7..1 and direction in bit 0
`timescale 1ns/1ps
`default_nettype none
`include "i2c_resv_defs.vh"
module first_byte_class (
	input wire [7:0] first_byte,
	output reg [3:0] byte_class
);
	wire [6:0] addr7 = first_byte[7:1];

	always @* begin
		byte_class = `CL_NORMAL;
		if (addr7 == `ADDR_GCALL && !first_byte[0])
			byte_class = `CL_GCALL;
		else if (addr7 == `ADDR_GCALL)
			byte_class = `CL_SBYTE;
		else if (addr7 == `ADDR_FOREIGN)
			byte_class = `CL_FOREIGN;
		else if (addr7 == `ADDR_FORMAT)
			byte_class = `CL_FORMAT;
		else if (addr7 == `ADDR_FUTURE)
			byte_class = `CL_FUTURE;
		else if (first_byte[7:3] == `PFX_HSCODE)
			byte_class = `CL_HSCODE;
		else if (first_byte[7:3] == `PFX_TENBIT)
			byte_class = `CL_TENBIT;
		else if (first_byte[7:3] == `PFX_DEVID)
			byte_class = `CL_DEVID;
	end
endmodule
`default_nettype wire

// [verilog/i2c_reserved_address_decoder.v]
// two-wire bus target that decodes the first byte after every start
// assumes clk far faster than the bus clock; no clock stretching is done
`timescale 1ns/1ps
`default_nettype none
`include "i2c_resv_defs.vh"
module i2c_reserved_address_decoder (
	input wire clk,
	input wire rst_n,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire [6:0] own_addr,
	input wire gcall_en,
	input wire bridge_en,
	input wire hs_capable,
	input wire [7:0] tx_data,
	output reg tx_taken,
	output reg [7:0] rx_data,
	output reg rx_valid,
	output reg selected,
	output reg is_read,
	output reg gc_cmd,
	output reg gc_reset,
	output reg hw_gcall,
	output reg [6:0] ctrl_addr,
	output reg hs_mode,
	output reg [2:0] hs_code,
	output reg poll_fast,
	output reg ten_bit_hdr,
	output reg [1:0] ten_bit_hi,
	output reg [3:0] last_class
);
	wire scl_s;
	wire sda_s;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire [3:0] byte_class;
	wire [7:0] byte_now;

	reg [2:0] state_r;
	reg [3:0] bit_cnt_r;
	reg in_ack_r;
	reg ack_pend_r;
	reg sda_oe_r;
	reg [7:0] shift_r;
	reg [7:0] tx_shift_r;

	bus_pin_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	// byte as it stands at the rising edge of its eighth clock
	assign byte_now = {shift_r[6:0], sda_s};

	first_byte_class u_class (
		.first_byte(byte_now),
		.byte_class(byte_class)
	);

	// open-drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= `ST_IDLE;
			bit_cnt_r <= 4'h0;
			in_ack_r <= 1'b0;
			ack_pend_r <= 1'b0;
			sda_oe_r <= 1'b0;
			shift_r <= 8'h00;
			tx_shift_r <= 8'hFF;
			tx_taken <= 1'b0;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			selected <= 1'b0;
			is_read <= 1'b0;
			gc_cmd <= 1'b0;
			gc_reset <= 1'b0;
			hw_gcall <= 1'b0;
			ctrl_addr <= 7'h00;
			hs_mode <= 1'b0;
			hs_code <= 3'h0;
			poll_fast <= 1'b0;
			ten_bit_hdr <= 1'b0;
			ten_bit_hi <= 2'h0;
			last_class <= `CL_NORMAL;
		end else begin
			tx_taken <= 1'b0;
			rx_valid <= 1'b0;
			gc_cmd <= 1'b0;
			gc_reset <= 1'b0;
			hw_gcall <= 1'b0;
			ten_bit_hdr <= 1'b0;
			if (stop_det) begin
				state_r <= `ST_IDLE;
				bit_cnt_r <= 4'h0;
				in_ack_r <= 1'b0;
				sda_oe_r <= 1'b0;
				selected <= 1'b0;
				hs_mode <= 1'b0;
				poll_fast <= 1'b0;
			end else if (start_det) begin
				// repeated start keeps hs_mode until a stop and selection until address known
				state_r <= `ST_ADDR;
				bit_cnt_r <= 4'h0;
				in_ack_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (scl_rise && state_r != `ST_IDLE) begin
				if (in_ack_r) begin
					// high in the ack slot of our own byte means the controller is done
					if (state_r == `ST_RD && sda_s)
						state_r <= `ST_SKIP;
				end else begin
					shift_r <= byte_now;
					bit_cnt_r <= bit_cnt_r + 4'h1;
					// slow pollers wake on a zero anywhere in the first byte after a start, start byte or not
					if (state_r == `ST_ADDR && !sda_s)
						poll_fast <= 1'b1;
					if (bit_cnt_r == `BIT_LAST) begin
						ack_pend_r <= 1'b0;
						case (state_r)
						`ST_ADDR: begin
							last_class <= byte_class;
							state_r <= `ST_SKIP;
							case (byte_class)
							`CL_NORMAL: begin
								// a reserved own_addr never reaches here, so never matches
								if (byte_now[7:1] == own_addr) begin
									selected <= 1'b1;
									is_read <= byte_now[0];
									ack_pend_r <= 1'b1;
									state_r <= byte_now[0] ? `ST_RD : `ST_WR;
								end else begin
									selected <= 1'b0;
								end
							end
							`CL_GCALL: begin
								selected <= 1'b0;
								is_read <= 1'b0;
								if (gcall_en) begin
									ack_pend_r <= 1'b1;
									state_r <= `ST_GCMD;
								end
							end
							`CL_FORMAT: begin
								// a bridge answers this address like its own
								selected <= bridge_en;
								if (bridge_en) begin
									ack_pend_r <= 1'b1;
									is_read <= byte_now[0];
									state_r <= byte_now[0] ? `ST_RD : `ST_WR;
								end
							end
							`CL_HSCODE: begin
								// codes are never acknowledged; the switch still happens when hs_capable is set
								selected <= 1'b0;
								hs_code <= byte_now[2:0];
								if (hs_capable)
									hs_mode <= 1'b1;
							end
							`CL_TENBIT: begin
								// extended addressing is flagged only, never answered here
								selected <= 1'b0;
								ten_bit_hdr <= 1'b1;
								ten_bit_hi <= byte_now[2:1];
							end
							default: begin
								// start byte, foreign bus, future, device id: stay silent
								selected <= 1'b0;
							end
							endcase
						end
						`ST_GCMD: begin
							ack_pend_r <= 1'b1;
							state_r <= `ST_WR;
							if (byte_now[0]) begin
								hw_gcall <= 1'b1;
								ctrl_addr <= byte_now[7:1];
							end else begin
								gc_cmd <= 1'b1;
								if (byte_now == `GC_RESET_CMD)
									gc_reset <= 1'b1;
							end
							rx_data <= byte_now;
						end
						`ST_WR: begin
							ack_pend_r <= 1'b1;
							rx_data <= byte_now;
							rx_valid <= 1'b1;
						end
						default: begin
							ack_pend_r <= 1'b0;
						end
						endcase
					end
				end
			end else if (scl_fall && state_r != `ST_IDLE) begin
				if (bit_cnt_r == `BIT_ACK) begin
					in_ack_r <= 1'b1;
					bit_cnt_r <= 4'h0;
					sda_oe_r <= ack_pend_r;
				end else if (in_ack_r) begin
					in_ack_r <= 1'b0;
					if (state_r == `ST_RD) begin
						tx_taken <= 1'b1;
						sda_oe_r <= ~tx_data[7];
						tx_shift_r <= {tx_data[6:0], 1'b1};
					end else begin
						sda_oe_r <= 1'b0;
					end
				end else if (state_r == `ST_RD && bit_cnt_r != 4'h0) begin
					sda_oe_r <= ~tx_shift_r[7];
					tx_shift_r <= {tx_shift_r[6:0], 1'b1};
				end else begin
					sda_oe_r <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/i2c_resv_monitor.sv]
// checker for the reserved-address decoder, watching top ports only
// assumes a bind from the bench and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "i2c_resv_defs.vh"
module i2c_resv_monitor (
	input wire clk,
	input wire rst_n,
	input wire sda_oe,
	input wire gcall_en,
	input wire bridge_en,
	input wire hs_capable,
	input wire [7:0] rx_data,
	input wire selected,
	input wire gc_cmd,
	input wire gc_reset,
	input wire hw_gcall,
	input wire hs_mode,
	input wire [3:0] last_class
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a bus bit lasts at least 8 clk, so any pull must too
	sequence s_bit;
		sda_oe [*8];
	endsequence
	property p_ack;
		$rose(sda_oe) |-> s_bit;
	endproperty
	a_ack: assert property (p_ack) else $error("pull shorter than a bit");
	property p_rst;
		gc_reset |-> gc_cmd && rx_data == `GC_RESET_CMD;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset command");
	property p_cmd;
		gc_cmd |-> !rx_data[0] && !hw_gcall && last_class == `CL_GCALL;
	endproperty
	a_cmd: assert property (p_cmd) else $error("bad command pulse");
	property p_hw;
		hw_gcall |-> rx_data[0] && gcall_en;
	endproperty
	a_hw: assert property (p_hw) else $error("bad hardware call");
	property p_hs;
		$rose(hs_mode) |-> hs_capable && last_class == `CL_HSCODE;
	endproperty
	a_hs: assert property (p_hs) else $error("bad speed switch");
	property p_nogc;
		last_class == `CL_GCALL && !gcall_en |-> !sda_oe;
	endproperty
	a_nogc: assert property (p_nogc) else $error("call acked while off");
	property p_resv;
		last_class inside {[4'h5:4'h8], 4'h2, 4'h3} |-> !sda_oe;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved code acked");
	property p_sel;
		$rose(selected) |-> last_class == `CL_NORMAL || (last_class == `CL_FORMAT && bridge_en);
	endproperty
	a_sel: assert property (p_sel) else $error("wrong selection");
	property p_hsdrop;
		$fell(hs_mode) |-> !selected;
	endproperty
	a_hsdrop: assert property (p_hsdrop) else $error("speed dropped early");
endmodule
`default_nettype wire

// [tb/bus_ctrl_model.sv]
// two-wire bus controller model, called through its tasks
// assumes the bench resolves the pulled-up data line
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_o
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	task hp;
		repeat (5) @(posedge clk);
	endtask
	// data first, then clock, so no false stop is seen
	task start;
		sda_o <= 1'b1;
		hp;
		scl <= 1'b1;
		hp;
		sda_o <= 1'b0;
		hp;
		scl <= 1'b0;
		hp;
	endtask
	task bitx(input logic b, output logic r);
		sda_o <= b;
		hp;
		scl <= 1'b1;
		hp;
		r = sda;
		scl <= 1'b0;
		hp;
	endtask
	task xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(a, r);
		ak = !r;
	endtask
	task stop;
		sda_o <= 1'b0;
		hp;
		scl <= 1'b1;
		hp;
		sda_o <= 1'b1;
		hp;
	endtask
endmodule
`default_nettype wire

// [tb/i2c_reserved_address_decoder_tb.sv]
// bench for the reserved-address decoder with a controller model
// assumes monitor and model compiled first, header on the include path
`timescale 1ns/1ps
`default_nettype none
module i2c_reserved_address_decoder_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] own_addr = 7'h3A;
	logic gcall_en = 1'b0;
	logic bridge_en = 1'b0;
	logic hs_capable = 1'b0;
	logic [7:0] tx_data = 8'hFF;
	logic [7:0] n_gc = 8'h00, n_rst = 8'h00, n_hw = 8'h00, n_rv = 8'h00, n_tt = 8'h00;
	int err_total = 0;
	int num_checks = 0;
	wire scl, sda_o, sda_out, sda_oe, tx_taken, rx_valid, selected, is_read;
	wire gc_cmd, gc_reset, hw_gcall, hs_mode, poll_fast, ten_bit_hdr;
	wire [7:0] rx_data;
	wire [6:0] ctrl_addr;
	wire [2:0] hs_code;
	wire [1:0] ten_bit_hi;
	wire [3:0] last_class;
	wire sda = sda_o & (sda_out | !sda_oe);
	i2c_reserved_address_decoder uut (.clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_oe, .own_addr, .gcall_en, .bridge_en, .hs_capable, .tx_data, .tx_taken,
		.rx_data, .rx_valid, .selected, .is_read, .gc_cmd, .gc_reset, .hw_gcall, .ctrl_addr,
		.hs_mode, .hs_code, .poll_fast, .ten_bit_hdr, .ten_bit_hi, .last_class);
	bus_ctrl_model m (.clk, .sda, .scl, .sda_o);
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		n_gc <= n_gc + {7'h00, gc_cmd === 1'b1};
		n_rst <= n_rst + {7'h00, gc_reset === 1'b1};
		n_hw <= n_hw + {7'h00, hw_gcall === 1'b1};
		n_rv <= n_rv + {7'h00, rx_valid === 1'b1};
		n_tt <= n_tt + {7'h00, tx_taken === 1'b1};
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task stop_test;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// {ack, class} that a first byte should give
	function automatic logic [4:0] want(input logic [7:0] b);
		if (b == 8'h00) return {gcall_en, 4'h1};
		if (b == 8'h01) return 5'h02;
		if (b[7:1] == 7'h01) return 5'h03;
		if (b[7:1] == 7'h02) return {bridge_en, 4'h4};
		if (b[7:1] == 7'h03) return 5'h05;
		if (b[7:3] == 5'h01) return 5'h06;
		if (b[7:3] == 5'h1E) return 5'h07;
		if (b[7:3] == 5'h1F) return 5'h08;
		return {b[7:1] == own_addr, 4'h0};
	endfunction
	initial begin
		#240000;
		err_total++;
		stop_test;
	end
	initial begin
		logic [7:0] q, d, c, t;
		logic ak;
		logic [4:0] e;
		void'($urandom(38271));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int b = 0; b < 256; b++) begin
			{gcall_en, bridge_en, hs_capable} <= 3'($urandom);
			own_addr <= 7'h08 + 7'($urandom % 112);
			@(posedge clk);
			e = want(8'(b));
			m.start;
			m.xfer(8'(b), 1'b1, q, ak);
			chk1(ak, e[4]);
			chk({4'h0, last_class}, {4'h0, e[3:0]});
			chk1(selected, e[4] && e[3:0] != 4'h1);
			chk1(hs_mode, hs_capable && e[3:0] == 4'h6);
			chk1(poll_fast, b != 255);
			if (e[3:0] == 4'h7) chk({6'h00, ten_bit_hi}, {6'h00, b[2:1]});
			m.stop;
			chk1(hs_mode | poll_fast | selected, 1'b0);
		end
		gcall_en <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			d = k == 0 ? 8'h06 : k == 1 ? 8'h0A : k == 2 ? 8'h2B : 8'($urandom);
			c = 8'($urandom);
			q = n_gc;
			e = {n_rst[3:0], n_hw[0]};
			m.start;
			m.xfer(8'h00, 1'b1, q, ak);
			q = n_gc;
			m.xfer(d, 1'b1, c, ak);
			chk1(ak, 1'b1);
			chk(n_gc - q, {7'h00, !d[0]});
			chk1(n_hw[0] ^ e[0], d[0]);
			chk1(n_rst[0] ^ e[1], d == 8'h06);
			if (d[0]) chk({1'b0, ctrl_addr}, {1'b0, d[7:1]});
			c = 8'($urandom);
			m.xfer(c, 1'b1, q, ak);
			chk1(ak, 1'b1);
			chk(rx_data, c);
			m.stop;
		end
		hs_capable <= 1'b1;
		own_addr <= 7'h2C;
		tx_data <= 8'($urandom);
		d = 8'($urandom);
		@(posedge clk);
		m.start;
		m.xfer(8'h0D, 1'b1, q, ak);
		chk({5'h00, hs_code}, 8'h05);
		m.start;
		m.xfer(8'h58, 1'b1, q, ak);
		chk1(ak, 1'b1);
		t = n_rv;
		m.xfer(d, 1'b1, q, ak);
		chk1(ak, 1'b1);
		chk(rx_data, d);
		chk(n_rv - t, 8'h01);
		t = n_tt;
		m.start;
		m.xfer(8'h59, 1'b1, q, ak);
		chk1(is_read, 1'b1);
		m.xfer(8'hFF, 1'b0, q, ak);
		chk(q, tx_data);
		m.xfer(8'hFF, 1'b1, q, ak);
		chk(q, tx_data);
		chk(n_tt - t, 8'h02);
		chk1(hs_mode, 1'b1);
		m.start;
		m.xfer(8'h5A, 1'b1, q, ak);
		chk1(selected | ak, 1'b0);
		m.stop;
		chk1(hs_mode, 1'b0);
		stop_test;
	end
endmodule
bind i2c_reserved_address_decoder i2c_resv_monitor mon (.clk, .rst_n, .sda_oe, .gcall_en,
	.bridge_en, .hs_capable, .rx_data, .selected, .gc_cmd, .gc_reset, .hw_gcall, .hs_mode,
	.last_class);
`default_nettype wire
